// ---- src/bbp_pkg.sv ----
// Package: shared constants for the backplane block paging exchange.
// Assumes a single 20 MHz clock and 16-bit image words.
package bbp_pkg;
  // ---------------------------------------------------------------
  // Image geometry
  // ---------------------------------------------------------------
  localparam int BBP_WORD_W = 16;
  localparam int BBP_IN_WORDS = 8;
  localparam int BBP_OUT_WORDS = 7;
  localparam int BBP_PAGE_WORDS = 6;
  localparam int BBP_IN_TAG_UP = 0;
  localparam int BBP_IN_TAG_DN = 1;
  localparam int BBP_IN_PAYLOAD = 2;
  localparam int BBP_OUT_TAG = 0;
  localparam int BBP_OUT_PAYLOAD = 1;
  // ---------------------------------------------------------------
  // Tag codes
  // ---------------------------------------------------------------
  localparam logic [15:0] BBP_TAG_NONE = 16'h0000;
  localparam logic [15:0] BBP_TAG_FIRST = 16'h0001;
  localparam logic [15:0] BBP_TAG_DATA_MAX = 16'h029A;
  localparam logic [15:0] BBP_TAG_EVT_LO = 16'h03E8;
  localparam logic [15:0] BBP_TAG_EVT_HI = 16'h04E7;
  localparam logic [15:0] BBP_TAG_CMD_BASE = 16'h07D0;
  localparam logic [15:0] BBP_TAG_CMD_LO = 16'h07D1;
  localparam logic [15:0] BBP_TAG_CMD_HI = 16'h07D6;
  localparam logic [15:0] BBP_TAG_WARM = 16'h270E;
  localparam logic [15:0] BBP_TAG_COLD = 16'h270F;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] BBP_RST_PREV_DN = 16'h0000;
  localparam logic [15:0] BBP_RST_WORD = 16'h0000;
endpackage

// ---- src/bbp_if.sv ----
// Interface: the two backplane images between module and processor.
// Both ends run on the same clock; no clocking block.
`timescale 1ns/100ps
interface bbp_if;
  import bbp_pkg::*;
  logic [BBP_WORD_W-1:0] in_img [BBP_IN_WORDS];
  logic [BBP_WORD_W-1:0] out_img [BBP_OUT_WORDS];
  modport dev (output in_img, input out_img);
  modport host (input in_img, output out_img);
endinterface

// ---- src/bbp_page_ctr.sv ----
// Page tag counter with wrap at the configured word total.
// Assumes the owner pulses adv_i once per completed page.
`timescale 1ns/100ps
module bbp_page_ctr
  import bbp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic init_i,
  input wire logic adv_i,
  input wire logic [15:0] word_total_i,
  output logic [15:0] tag_o
);
  logic [15:0] tag;
  logic [15:0] next_tag;
  logic [19:0] next_end;

  always_comb begin
    next_tag = tag;
    next_end = 20'(tag + 16'h0001) * 20'(BBP_PAGE_WORDS);
    if (init_i) begin
      next_tag = BBP_TAG_FIRST;
    end else if (adv_i) begin
      if (next_end > 20'(word_total_i) || tag >= BBP_TAG_DATA_MAX) begin
        next_tag = BBP_TAG_FIRST;
      end else begin
        next_tag = tag + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tag <= BBP_TAG_FIRST;
    end else begin
      tag <= next_tag;
    end
  end

  assign tag_o = tag;
endmodule // bbp_page_ctr

// ---- src/bbp_dev.sv ----
// Module end: gateway side that drives the eight-word input image.
// Assumes the processor end shares ref_clk_i and keeps its own image stable
// while its tag word is unchanged.
//
// Behaviour
// - Eight-word input, seven-word output image
// - Each side drives only its own image
// - Six payload words per block
// - Header: upload tag, download tag, payload
// - Data tags 0..666; zero ignored
// - Tag n addresses n-th six-word page
// - Changed word 0 means new block
// - Init: both tags one, previous download zero
// - Load payload, then download tag, upload last
// - Processor stores upload page at offset
// - Processor loads page, then writes tag
// - Store downloaded page, record its tag
// - Pick next pages and repeat forever
// - Bases and totals come from configuration
// - Tags 1000..1255 request event command
// - Tags 2001..2006 request command list
// - Tag 9998 warm restart
// - Tag 9999 full hardware restart
// - Processor writes control payload before tag
`timescale 1ns/100ps
module bbp_dev
  import bbp_pkg::*;
#(
  parameter int DB_AW = 12
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  bbp_if.dev img,
  input wire logic [DB_AW-1:0] inbound_db_base_i,
  input wire logic [DB_AW-1:0] outbound_db_base_i,
  input wire logic [15:0] inbound_word_total_i,
  input wire logic [15:0] outbound_word_total_i,
  output logic [DB_AW-1:0] db_addr_o,
  output logic db_rd_o,
  input wire logic [15:0] db_rdata_i,
  output logic db_wr_o,
  output logic [15:0] db_wdata_o,
  output logic evt_req_o,
  output logic [7:0] evt_slave_o,
  output logic cmd_req_o,
  output logic [2:0] cmd_count_o,
  output logic warm_boot_o,
  output logic cold_boot_o,
  output logic [95:0] ctl_payload_o
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_LOAD = 3'b001,
    ST_HDR = 3'b010,
    ST_TRIG = 3'b011,
    ST_WAIT = 3'b100,
    ST_STORE = 3'b101
  } bbp_dev_st_e;

  bbp_dev_st_e st, next_st;
  logic [2:0] idx, next_idx;
  logic [15:0] prev_dn, next_prev_dn;
  logic [15:0] in_w [BBP_IN_WORDS];
  logic [15:0] next_in_w [BBP_IN_WORDS];
  logic [DB_AW-1:0] db_addr, next_db_addr;
  logic db_rd, next_db_rd, db_wr, next_db_wr;
  logic [15:0] db_wdata, next_db_wdata;
  logic evt_req, next_evt_req, cmd_req, next_cmd_req;
  logic [7:0] evt_slave, next_evt_slave;
  logic [2:0] cmd_count, next_cmd_count;
  logic warm, next_warm, cold, next_cold;
  logic [95:0] ctl_pl, next_ctl_pl;
  logic rd_pend, next_rd_pend;
  logic [15:0] boot_tag, next_boot_tag;
  logic init_tags, adv_up, adv_dn;
  logic [15:0] up_tag, dn_tag, rx_tag;
  logic [15:0] pg_up, pg_dn;

  // ---------------------------------------------------------------
  // Page counters
  // ---------------------------------------------------------------
  bbp_page_ctr u_up (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .init_i(init_tags),
    .adv_i(adv_up),
    .word_total_i(outbound_word_total_i),
    .tag_o(up_tag)
  );

  bbp_page_ctr u_dn (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .init_i(init_tags),
    .adv_i(adv_dn),
    .word_total_i(inbound_word_total_i),
    .tag_o(dn_tag)
  );

  assign rx_tag = img.out_img[BBP_OUT_TAG];
  // Page offsets (tag - 1) * 6, cut to 16 bits
  assign pg_up = 16'((up_tag - 16'h0001) * 16'(BBP_PAGE_WORDS));
  assign pg_dn = 16'((rx_tag - 16'h0001) * 16'(BBP_PAGE_WORDS));

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_idx = idx;
    next_prev_dn = prev_dn;
    next_in_w = in_w;
    next_db_addr = db_addr;
    next_db_rd = 1'b0;
    next_db_wr = 1'b0;
    next_db_wdata = db_wdata;
    next_evt_req = 1'b0;
    next_evt_slave = evt_slave;
    next_cmd_req = 1'b0;
    next_cmd_count = cmd_count;
    next_warm = 1'b0;
    next_cold = 1'b0;
    next_ctl_pl = ctl_pl;
    next_rd_pend = 1'b0;
    // Boot tag lingers in the image after restart; act on it only once
    next_boot_tag = (rx_tag == boot_tag) ? boot_tag : BBP_TAG_NONE;
    init_tags = 1'b0;
    adv_up = 1'b0;
    adv_dn = 1'b0;
    case (st)
      ST_INIT: begin
        init_tags = 1'b1;
        next_prev_dn = BBP_RST_PREV_DN;
        next_idx = 3'd0;
        next_st = ST_LOAD;
      end
      ST_LOAD: begin
        // Read one database word a cycle; data returns next cycle
        if (rd_pend) begin
          next_in_w[BBP_IN_PAYLOAD + 32'(idx) - 1] = db_rdata_i;
        end
        if (idx < 3'(BBP_PAGE_WORDS)) begin
          next_db_addr = outbound_db_base_i + DB_AW'(pg_up) + DB_AW'(idx);
          next_db_rd = 1'b1;
          next_rd_pend = 1'b1;
          next_idx = idx + 3'd1;
        end else if (!rd_pend) begin
          next_st = ST_HDR;
        end
      end
      ST_HDR: begin
        next_in_w[BBP_IN_TAG_DN] = dn_tag;
        next_st = ST_TRIG;
      end
      ST_TRIG: begin
        next_in_w[BBP_IN_TAG_UP] = up_tag;
        next_st = ST_WAIT;
      end
      ST_WAIT: begin
        if (rx_tag != prev_dn && (boot_tag == BBP_TAG_NONE || rx_tag != boot_tag)) begin
          next_prev_dn = rx_tag;
          next_idx = 3'd0;
          if (rx_tag == BBP_TAG_NONE) begin
            next_st = ST_WAIT;
          end else if (rx_tag <= BBP_TAG_DATA_MAX) begin
            next_prev_dn = prev_dn;
            next_st = ST_STORE;
          end else if (rx_tag >= BBP_TAG_EVT_LO && rx_tag <= BBP_TAG_EVT_HI) begin
            next_evt_req = 1'b1;
            next_evt_slave = 8'(rx_tag - BBP_TAG_EVT_LO);
            next_ctl_pl = {img.out_img[6], img.out_img[5], img.out_img[4],
                           img.out_img[3], img.out_img[2], img.out_img[1]};
            adv_up = 1'b1;
            next_st = ST_LOAD;
          end else if (rx_tag >= BBP_TAG_CMD_LO && rx_tag <= BBP_TAG_CMD_HI) begin
            next_cmd_req = 1'b1;
            next_cmd_count = 3'(rx_tag - BBP_TAG_CMD_BASE);
            next_ctl_pl = {img.out_img[6], img.out_img[5], img.out_img[4],
                           img.out_img[3], img.out_img[2], img.out_img[1]};
            adv_up = 1'b1;
            next_st = ST_LOAD;
          end else if (rx_tag == BBP_TAG_WARM) begin
            next_warm = 1'b1;
            next_boot_tag = rx_tag;
            next_st = ST_INIT;
          end else if (rx_tag == BBP_TAG_COLD) begin
            next_cold = 1'b1;
            next_boot_tag = rx_tag;
            next_st = ST_INIT;
          end else begin
            // Keep paging, or the processor end waits forever
            adv_up = 1'b1;
            next_st = ST_LOAD;
          end
        end
      end
      ST_STORE: begin
        if (idx < 3'(BBP_PAGE_WORDS)) begin
          next_db_addr = inbound_db_base_i + DB_AW'(pg_dn) + DB_AW'(idx);
          next_db_wdata = img.out_img[BBP_OUT_PAYLOAD + 32'(idx)];
          next_db_wr = 1'b1;
          next_idx = idx + 3'd1;
        end else begin
          next_prev_dn = rx_tag;
          adv_up = 1'b1;
          adv_dn = 1'b1;
          next_idx = 3'd0;
          next_st = ST_LOAD;
        end
      end
      default: next_st = ST_INIT;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st <= ST_INIT;
      idx <= 3'd0;
      prev_dn <= BBP_RST_PREV_DN;
      for (int i = 0; i < BBP_IN_WORDS; i++) begin
        in_w[i] <= BBP_RST_WORD;
      end
      db_addr <= '0;
      db_rd <= 1'b0;
      db_wr <= 1'b0;
      db_wdata <= BBP_RST_WORD;
      evt_req <= 1'b0;
      evt_slave <= 8'h00;
      cmd_req <= 1'b0;
      cmd_count <= 3'h0;
      warm <= 1'b0;
      cold <= 1'b0;
      ctl_pl <= '0;
      rd_pend <= 1'b0;
      boot_tag <= BBP_TAG_NONE;
    end else begin
      st <= next_st;
      idx <= next_idx;
      prev_dn <= next_prev_dn;
      in_w <= next_in_w;
      db_addr <= next_db_addr;
      db_rd <= next_db_rd;
      db_wr <= next_db_wr;
      db_wdata <= next_db_wdata;
      evt_req <= next_evt_req;
      evt_slave <= next_evt_slave;
      cmd_req <= next_cmd_req;
      cmd_count <= next_cmd_count;
      warm <= next_warm;
      cold <= next_cold;
      ctl_pl <= next_ctl_pl;
      rd_pend <= next_rd_pend;
      boot_tag <= next_boot_tag;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Only this end drives the input image
  assign img.in_img = in_w;
  assign db_addr_o = db_addr;
  assign db_rd_o = db_rd;
  assign db_wr_o = db_wr;
  assign db_wdata_o = db_wdata;
  assign evt_req_o = evt_req;
  assign evt_slave_o = evt_slave;
  assign cmd_req_o = cmd_req;
  assign cmd_count_o = cmd_count;
  assign warm_boot_o = warm;
  assign cold_boot_o = cold;
  assign ctl_payload_o = ctl_pl;
endmodule // bbp_dev

// ---- src/bbp_host.sv ----
// Processor end: ladder logic side that drives the seven-word output image.
// Assumes a user data file whose read data stands while file_rd_o is high.
`timescale 1ns/100ps
module bbp_host
  import bbp_pkg::*;
#(
  parameter int FILE_AW = 12
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  bbp_if.host img,
  output logic [FILE_AW-1:0] file_addr_o,
  output logic file_rd_o,
  input wire logic [15:0] file_rdata_i,
  output logic file_wr_o,
  output logic [15:0] file_wdata_o,
  input wire logic ctl_req_i,
  input wire logic [15:0] ctl_tag_i,
  input wire logic [95:0] ctl_payload_i,
  output logic ctl_busy_o
);
  typedef enum logic [1:0] {
    HS_WAIT = 2'b00,
    HS_COPY = 2'b01,
    HS_FETCH = 2'b10,
    HS_TRIG = 2'b11
  } bbp_host_st_e;

  bbp_host_st_e st, next_st;
  logic [2:0] idx, next_idx;
  logic [15:0] prev_up, next_prev_up;
  logic [15:0] tag, next_tag;
  logic ctl, next_ctl, pend, next_pend, rd_pend, next_rd_pend;
  logic [15:0] o_w [BBP_OUT_WORDS];
  logic [15:0] next_o_w [BBP_OUT_WORDS];
  logic [FILE_AW-1:0] f_addr, next_f_addr;
  logic f_rd, next_f_rd, f_wr, next_f_wr;
  logic [15:0] f_wd, next_f_wd;
  logic [15:0] rx_up;

  assign rx_up = img.in_img[BBP_IN_TAG_UP];

  always_comb begin
    next_st = st;
    next_idx = idx;
    next_prev_up = prev_up;
    next_tag = tag;
    next_ctl = ctl;
    next_pend = pend;
    next_o_w = o_w;
    next_f_addr = f_addr;
    next_f_rd = 1'b0;
    next_f_wr = 1'b0;
    next_f_wd = f_wd;
    next_rd_pend = 1'b0;
    if (ctl_req_i) begin
      next_pend = 1'b1;
    end
    case (st)
      HS_WAIT: begin
        if (rx_up != prev_up && rx_up != BBP_TAG_NONE) begin
          next_idx = 3'd0;
          next_st = HS_COPY;
        end
      end
      HS_COPY: begin
        if (idx < 3'(BBP_PAGE_WORDS)) begin
          next_f_addr = FILE_AW'((rx_up - 16'h0001) * 16'(BBP_PAGE_WORDS))
            + FILE_AW'(idx);
          next_f_wd = img.in_img[BBP_IN_PAYLOAD + 32'(idx)];
          next_f_wr = 1'b1;
          next_idx = idx + 3'd1;
        end else begin
          next_prev_up = rx_up;
          next_idx = 3'd0;
          // Control only after a fresh upload block
          if (pend || ctl_req_i) begin
            next_pend = 1'b0;
            next_ctl = 1'b1;
            next_tag = ctl_tag_i;
            for (int i = 0; i < BBP_PAGE_WORDS; i++) begin
              next_o_w[BBP_OUT_PAYLOAD + i] = ctl_payload_i[16*i +: 16];
            end
            next_st = HS_TRIG;
          end else begin
            next_ctl = 1'b0;
            next_tag = img.in_img[BBP_IN_TAG_DN];
            next_st = HS_FETCH;
          end
        end
      end
      HS_FETCH: begin
        if (rd_pend) begin
          next_o_w[BBP_OUT_PAYLOAD + 32'(idx) - 1] = file_rdata_i;
        end
        if (idx < 3'(BBP_PAGE_WORDS)) begin
          next_f_addr = FILE_AW'((tag - 16'h0001) * 16'(BBP_PAGE_WORDS)) + FILE_AW'(idx);
          next_f_rd = 1'b1;
          next_rd_pend = 1'b1;
          next_idx = idx + 3'd1;
        end else if (!rd_pend) begin
          next_st = HS_TRIG;
        end
      end
      HS_TRIG: begin
        next_o_w[BBP_OUT_TAG] = tag;
        next_st = HS_WAIT;
      end
      default: next_st = HS_WAIT;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st <= HS_WAIT;
      idx <= 3'd0;
      prev_up <= BBP_TAG_NONE;
      tag <= BBP_TAG_NONE;
      ctl <= 1'b0;
      pend <= 1'b0;
      rd_pend <= 1'b0;
      for (int i = 0; i < BBP_OUT_WORDS; i++) begin
        o_w[i] <= BBP_RST_WORD;
      end
      f_addr <= '0;
      f_rd <= 1'b0;
      f_wr <= 1'b0;
      f_wd <= BBP_RST_WORD;
    end else begin
      st <= next_st;
      idx <= next_idx;
      prev_up <= next_prev_up;
      tag <= next_tag;
      ctl <= next_ctl;
      pend <= next_pend;
      rd_pend <= next_rd_pend;
      o_w <= next_o_w;
      f_addr <= next_f_addr;
      f_rd <= next_f_rd;
      f_wr <= next_f_wr;
      f_wd <= next_f_wd;
    end
  end

  // Only this end drives the output image
  assign img.out_img = o_w;
  assign file_addr_o = f_addr;
  assign file_rd_o = f_rd;
  assign file_wr_o = f_wr;
  assign file_wdata_o = f_wd;
  assign ctl_busy_o = pend;
endmodule // bbp_host

// ---- verif/bbp_properties.sv ----
// Checker: handshake relations on the two backplane images.
// Assumes a shared ref_clk_i and word totals of at least two pages.
`timescale 1ns/100ps
module bbp_properties
  import bbp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [BBP_WORD_W-1:0] in_img [BBP_IN_WORDS],
  input wire logic [BBP_WORD_W-1:0] out_img [BBP_OUT_WORDS]
);
  // ----------
  // Helpers
  // ----------
  logic [95:0] in_pay;
  logic [95:0] out_pay;
  logic out_data;
  logic out_ctl;
  logic out_boot;
  assign in_pay = {in_img[7], in_img[6], in_img[5], in_img[4], in_img[3], in_img[2]};
  assign out_pay = {out_img[6], out_img[5], out_img[4], out_img[3], out_img[2], out_img[1]};
  assign out_data = out_img[0] != BBP_TAG_NONE && out_img[0] <= BBP_TAG_DATA_MAX;
  assign out_ctl = (out_img[0] >= BBP_TAG_EVT_LO && out_img[0] <= BBP_TAG_EVT_HI) ||
    (out_img[0] >= BBP_TAG_CMD_LO && out_img[0] <= BBP_TAG_CMD_HI);
  assign out_boot = out_img[0] == BBP_TAG_WARM || out_img[0] == BBP_TAG_COLD;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  // ----------
  // Assertions
  // ----------
  init_tags_a: assert property ($fell(rst_i) |-> ##[1:16]
    (in_img[0] == BBP_TAG_FIRST && in_img[1] == BBP_TAG_FIRST))
    else $error("tags not one after reset");
  tag_range_a: assert property (
    in_img[0] <= BBP_TAG_DATA_MAX && in_img[1] <= BBP_TAG_DATA_MAX)
    else $error("device tag outside data range");
  up_last_a: assert property (
    $changed(in_img[0]) |-> $stable(in_pay) && $stable(in_img[1]))
    else $error("upload tag not written last");
  dn_then_up_a: assert property (
    $changed(in_img[1]) |-> ##[1:2] $changed(in_img[0]))
    else $error("upload tag late after download tag");
  host_last_a: assert property ($changed(out_img[0]) |-> $stable(out_pay))
    else $error("answer tag not written last");
  // Bounds suit this block's fixed copy and fetch lengths
  host_answer_a: assert property (
    $changed(in_img[0]) && in_img[0] != BBP_TAG_NONE |-> ##[1:40] $changed(out_img[0]))
    else $error("processor end gave no answer");
  dev_answer_a: assert property (
    $changed(out_img[0]) && out_data |-> ##[1:40] $changed(in_img[0]))
    else $error("device end gave no next block");
  ctl_next_a: assert property (
    $changed(out_img[0]) && out_ctl |-> ##[1:40] ($changed(in_img[0]) && $stable(in_img[1])))
    else $error("control tag not followed by upload");
  restart_a: assert property (
    $changed(out_img[0]) && out_boot |-> ##[1:40]
    (in_img[0] == BBP_TAG_FIRST && in_img[1] == BBP_TAG_FIRST))
    else $error("restart did not reset tags");
  wrap_c: cover property ($changed(in_img[0]) && in_img[0] == BBP_TAG_FIRST);
  ctl_c: cover property ($changed(out_img[0]) && out_ctl);
  boot_c: cover property ($changed(out_img[0]) && out_boot);
endmodule // bbp_properties

// ---- verif/backplane_block_paging_bench.sv ----
// Bench: both ends joined over the image interface, with memory models.
// Assumes read data stands with its strobe; totals of two pages so tags wrap.
`timescale 1ns/100ps
module backplane_block_paging_bench
  import bbp_pkg::*;
;
  // ----------
  // Models
  // ----------
  localparam logic [11:0] IB = 12'h100;
  localparam logic [11:0] OB = 12'h010;
  localparam logic [95:0] PAY = 96'h0006_0005_0004_0003_0002_0001;
  logic ref_clk_i, rst_i, db_rd, db_wr, f_rd, f_wr, evt, cmd, warm, cold, req, busy;
  logic [11:0] db_a, f_a;
  logic [15:0] db_q, db_d, f_q, f_d, tag, up, dn, ans;
  logic [15:0] db [4096];
  logic [15:0] fm [4096];
  logic [7:0] slave;
  logic [2:0] count;
  logic [95:0] pay, dev_pay, evt_pay;
  int evt_n = 0, cmd_n = 0, warm_n = 0, cold_n = 0, err_total = 0, checked = 0;
  bbp_if bbp_if_inst ();
  assign up = bbp_if_inst.in_img[0];
  assign dn = bbp_if_inst.in_img[1];
  assign ans = bbp_if_inst.out_img[0];
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // Read data stands with the strobe; inverted otherwise so a stray sample fails
  assign db_q = db_rd === 1'b1 ? db[db_a] : ~db[db_a];
  assign f_q = f_rd === 1'b1 ? fm[f_a] : ~fm[f_a];
  always @(posedge ref_clk_i) begin
    if (db_wr === 1'b1) db[db_a] <= db_d;
    if (f_wr === 1'b1) fm[f_a] <= f_d;
    if (evt === 1'b1) evt_pay <= dev_pay;
    evt_n <= evt_n + int'(evt === 1'b1);
    cmd_n <= cmd_n + int'(cmd === 1'b1);
    warm_n <= warm_n + int'(warm === 1'b1);
    cold_n <= cold_n + int'(cold === 1'b1);
  end
  bbp_dev #(.DB_AW(12)) bbp_dev_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .img(bbp_if_inst.dev), .inbound_db_base_i(IB), .outbound_db_base_i(OB),
    .inbound_word_total_i(16'h000C), .outbound_word_total_i(16'h000C),
    .db_addr_o(db_a), .db_rd_o(db_rd), .db_rdata_i(db_q), .db_wr_o(db_wr),
    .db_wdata_o(db_d), .evt_req_o(evt), .evt_slave_o(slave), .cmd_req_o(cmd),
    .cmd_count_o(count), .warm_boot_o(warm), .cold_boot_o(cold), .ctl_payload_o(dev_pay));
  bbp_host #(.FILE_AW(12)) bbp_host_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .img(bbp_if_inst.host), .file_addr_o(f_a), .file_rd_o(f_rd), .file_rdata_i(f_q),
    .file_wr_o(f_wr), .file_wdata_o(f_d), .ctl_req_i(req), .ctl_tag_i(tag),
    .ctl_payload_i(pay), .ctl_busy_o(busy));
  bbp_properties bbp_properties_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .in_img(bbp_if_inst.in_img), .out_img(bbp_if_inst.out_img));
  // ----------
  // Tasks
  // ----------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Waits on upload tag (0), answer tag (1) or busy (2)
  task automatic wait_for(input int sel, input logic [15:0] v);
    int n = 0;
    logic [15:0] s;
    do begin
      @(posedge ref_clk_i);
      #1;
      n++;
      s = sel == 0 ? up : sel == 1 ? ans : 16'(busy);
    end while (n < 300 && s !== v);
    if (s !== v) begin
      err_total++;
      $display("[FAIL] wait %0d expected %h seen %h", sel, v, s);
      print_verdict();
    end
  endtask
  task automatic reset_check();
    rst_i <= 1'b0;
    #1;
    chk("upload tag in reset", BBP_RST_WORD, up);
    chk("answer tag in reset", BBP_RST_WORD, ans);
    wait_for(0, BBP_TAG_FIRST);
    chk("first download tag", BBP_TAG_FIRST, dn);
    chk("first payload word", 16'hA000 | 16'(OB), bbp_if_inst.in_img[2]);
  endtask
  task automatic data_paging();
    wait_for(0, 16'h0002);
    wait_for(0, BBP_TAG_FIRST);
    wait_for(0, 16'h0002);
    for (int k = 0; k < 12; k++) begin
      chk("file word", 16'(16'hA000 + OB + k), fm[k]);
      chk("inbound word", 16'(16'hA000 + OB + k), db[IB + 12'(k)]);
    end
    chk("file past total", 16'h500C, fm[12]);
    chk("inbound past total", 16'hA10C, db[IB + 12'h00C]);
  endtask
  // Request goes in once an answer is out, so the answer to the next upload carries it
  task automatic ctl_tags();
    logic [15:0] codes [5] = '{16'h03ED, 16'h07D3, 16'h02BC, BBP_TAG_WARM, BBP_TAG_COLD};
    int n0 [4];
    for (int i = 0; i < 5; i++) begin
      wait_for(0, 16'h0002);
      wait_for(0, BBP_TAG_FIRST);
      wait_for(1, dn);
      n0 = '{evt_n, cmd_n, warm_n, cold_n};
      @(posedge ref_clk_i);
      tag <= codes[i];
      pay <= PAY;
      req <= 1'b1;
      @(posedge ref_clk_i);
      req <= 1'b0;
      wait_for(2, 16'h0000);
      repeat (40) @(posedge ref_clk_i);
      chk("event pulses", 16'(i == 0), 16'(evt_n - n0[0]));
      chk("command pulses", 16'(i == 1), 16'(cmd_n - n0[1]));
      chk("warm pulses", 16'(i == 3), 16'(warm_n - n0[2]));
      chk("cold pulses", 16'(i == 4), 16'(cold_n - n0[3]));
      if (i == 0) begin
        chk("event slave", 16'h0005, 16'(slave));
        for (int w = 0; w < 6; w++) begin
          chk("event payload", PAY[16*w +: 16], evt_pay[16*w +: 16]);
        end
      end
      if (i == 1) chk("command count", 16'h0003, 16'(count));
    end
  endtask
  initial begin
    for (int i = 0; i < 4096; i++) begin
      db[i] = 16'hA000 | 16'(i);
      fm[i] = 16'h5000 | 16'(i);
    end
    rst_i <= 1'b1;
    req <= 1'b0;
    tag <= BBP_TAG_NONE;
    pay <= '0;
    repeat (4) @(posedge ref_clk_i);
    reset_check();
    data_paging();
    ctl_tags();
    print_verdict();
  end
endmodule // backplane_block_paging_bench
